// ---- design/serial_cmd_pkg.sv ----
/*
 * shared constants and carriers for the expansion serial command decoder.
 * assumes a 125 MHz system clock and a separate serial link clock.
 */
package serial_cmd_pkg;

    // ------------------------------------------------------------
    // opcode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] register_read_op      = 4'h0;
    localparam logic [3:0] register_write_op     = 4'h1;
    localparam logic [3:0] set_reset_bit_op      = 4'h2;
    localparam logic [3:0] set_fast_clock_op     = 4'h4;
    localparam logic [3:0] route_next_op         = 4'h8;
    localparam logic [3:0] chain_reset_op        = 4'h9;
    localparam logic [3:0] clear_reset_bit_op    = 4'hB;
    localparam logic [3:0] eeprom_byte_write_op  = 4'hD;
    localparam logic [3:0] eeprom_random_read_op = 4'hE;

    // ------------------------------------------------------------
    // chip select codes, register offsets, reset values
    // ------------------------------------------------------------
    localparam logic [4:0]  chip_all_hubs          = 5'h1F;
    localparam logic [4:0]  chip_stick_base        = 5'h10;
    localparam logic [11:0] eeprom_read_result_adr = 12'h040;
    localparam logic [11:0] scratch_reg_adr        = 12'h041;
    localparam int          result_valid_bit       = 15;
    localparam logic [15:0] result_reset           = 16'h0000;
    localparam logic [15:0] scratch_reset          = 16'h0000;
    localparam logic [4:0]  own_chip_reset         = 5'h00;
    localparam logic [1:0]  strap_capture_cnt      = 2'h2;

    // ------------------------------------------------------------
    // packet carrier: request, chip select, address, data
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  opcode_field;
        logic [4:0]  chip_select_field;
        logic [11:0] register_address_field;
        logic [15:0] packet_data_field;
    } packet_t;

    typedef struct packed {
        logic [1:0]  kind;
        logic [7:0]  slave_address;
        logic [7:0]  byte_address;
        logic [7:0]  write_byte;
    } eeprom_req_t;

    localparam logic [1:0] eeprom_kind_write   = 2'h1;
    localparam logic [1:0] eeprom_kind_setaddr = 2'h2;
    localparam logic [1:0] eeprom_kind_read    = 2'h3;

endpackage

// ---- design/expansion_serial_command_decoder.sv ----
/*
 * command decoder for serial control packets on the expansion control bus.
 * assumes packets arrive already assembled on the link clock, with a one-cycle
 * strobe; an external smbus engine takes eeprom requests with valid/ready.
 */
`timescale 1ns/1ps

module expansion_serial_command_decoder
    import serial_cmd_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        link_clk_in,
    input  wire logic        link_rst_n_in,
    input  wire logic [4:0]  own_chip_id_in,
    input  wire logic        packet_valid_in,
    input  wire packet_t     packet_in,
    output logic             read_valid_out,
    output logic [15:0]      read_data_out,
    output logic             forward_valid_out,
    output packet_t          forward_packet_out,
    output logic [4:0]       forward_chip_out,
    output logic             chain_reset_out,
    output logic [4:0]       chain_reset_chip_out,
    output logic             eeprom_valid_out,
    output eeprom_req_t      eeprom_req_out,
    input  wire logic        eeprom_ready_in,
    input  wire logic        eeprom_done_in,
    input  wire logic [7:0]  eeprom_data_in
);

    // ------------------------------------------------------------
    // link domain: packet capture and event toggle
    // ------------------------------------------------------------
    typedef struct packed {
        packet_t pkt_r;
        logic    tog_r;
    } link_state_t;

    link_state_t ls_r;
    link_state_t ls_nxt;

    always_comb
    begin
        ls_nxt = ls_r;
        if (packet_valid_in)
        begin
            // word held stable until the next strobe replaces it
            ls_nxt.pkt_r = packet_in;
            ls_nxt.tog_r = ~ls_r.tog_r;
        end
    end

    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n_in)
            ls_r <= '0;
        else
            ls_r <= ls_nxt;
    end

    // ------------------------------------------------------------
    // system domain state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ee_idle, ee_setaddr, ee_read, ee_wait} ee_state_t;

    typedef struct packed {
        logic [2:0]  sync_r;
        logic [4:0]  chip_r;
        logic        route_r;
        logic [4:0]  route_chip_r;
        logic [15:0] result_r;
        logic [15:0] scratch_r;
        logic        read_valid_r;
        logic [15:0] read_data_r;
        logic        fwd_valid_r;
        packet_t     fwd_pkt_r;
        logic [4:0]  fwd_chip_r;
        logic        chain_r;
        logic [4:0]  chain_chip_r;
        logic        ee_valid_r;
        eeprom_req_t ee_req_r;
        ee_state_t   ee_st_r;
        logic [4:0]  strap_meta_r;
        logic [4:0]  strap_sync_r;
        logic [1:0]  strap_cnt_r;
        logic        done_prev_r;
    } sys_state_t;

    sys_state_t s_r;
    sys_state_t s_nxt;

    logic    pkt_event;
    packet_t pkt;
    logic    for_me;
    logic    done_pulse;
    logic    ee_busy;
    logic    to_stick;

    // sync_r[0] is only read by sync_r[1]; edge uses stages 1 and 2
    assign pkt_event  = s_r.sync_r[2] ^ s_r.sync_r[1];
    // link side holds the word until its next strobe, so it is settled once the toggle crossed
    assign pkt        = ls_r.pkt_r;
    assign for_me     = (pkt.chip_select_field == s_r.chip_r) ||
                        (pkt.chip_select_field == chip_all_hubs);
    assign to_stick   = (pkt.chip_select_field & chip_stick_base) == chip_stick_base;
    // engine shares this clock, so its done toggle is compared without synchronising
    assign done_pulse = s_r.done_prev_r ^ eeprom_done_in;
    assign ee_busy    = s_r.ee_valid_r || (s_r.ee_st_r != ee_idle);

    always_comb
    begin
        s_nxt              = s_r;
        s_nxt.sync_r       = {s_r.sync_r[1:0], ls_r.tog_r};
        s_nxt.done_prev_r  = eeprom_done_in;
        s_nxt.read_valid_r = 1'b0;
        s_nxt.fwd_valid_r  = 1'b0;
        s_nxt.chain_r      = 1'b0;

        // ------------------------------------------------------------
        // chip id strap
        // ------------------------------------------------------------
        // strap is a pin: two flops first, then caught once and held for the run
        s_nxt.strap_meta_r = own_chip_id_in;
        s_nxt.strap_sync_r = s_r.strap_meta_r;
        if (!(&s_r.strap_cnt_r))
            s_nxt.strap_cnt_r = s_r.strap_cnt_r + 2'h1;
        if (s_r.strap_cnt_r == strap_capture_cnt)
            s_nxt.chip_r = s_r.strap_sync_r;

        // ------------------------------------------------------------
        // eeprom sequencing
        // ------------------------------------------------------------
        if (s_r.ee_valid_r && eeprom_ready_in)
            s_nxt.ee_valid_r = 1'b0;
        unique case (s_r.ee_st_r)
            ee_idle:
            begin
            end
            ee_setaddr:
            begin
                // address write must be issued before the read
                if (s_r.ee_valid_r && eeprom_ready_in)
                begin
                    s_nxt.ee_req_r.kind = eeprom_kind_read;
                    s_nxt.ee_valid_r    = 1'b1;
                    s_nxt.ee_st_r       = ee_read;
                end
            end
            ee_read:
            begin
                if (s_r.ee_valid_r && eeprom_ready_in)
                    s_nxt.ee_st_r = ee_wait;
            end
            ee_wait:
            begin
                if (done_pulse)
                begin
                    s_nxt.result_r = {1'b1, 7'h00, eeprom_data_in};
                    s_nxt.ee_st_r  = ee_idle;
                end
            end
        endcase

        // ------------------------------------------------------------
        // packet decode
        // ------------------------------------------------------------
        if (pkt_event)
        begin
            if (s_r.route_r)
            begin
                // routed command leaves this hub untouched
                s_nxt.fwd_valid_r = 1'b1;
                s_nxt.fwd_pkt_r   = pkt;
                s_nxt.fwd_chip_r  = s_r.route_chip_r;
                s_nxt.route_r     = 1'b0;
            end
            else
            begin
                unique case (pkt.opcode_field)
                    register_read_op:
                    begin
                        if (for_me)
                        begin
                            s_nxt.read_valid_r = 1'b1;
                            unique case (pkt.register_address_field)
                                eeprom_read_result_adr:
                                begin
                                    s_nxt.read_data_r = s_r.result_r;
                                    // a result landing this cycle keeps its valid bit
                                    if (!(s_r.ee_st_r == ee_wait && done_pulse))
                                        s_nxt.result_r[result_valid_bit] = 1'b0;
                                end
                                scratch_reg_adr:
                                    s_nxt.read_data_r = s_r.scratch_r;
                                default:
                                    s_nxt.read_data_r = 16'h0000;
                            endcase
                        end
                    end
                    register_write_op:
                    begin
                        if (for_me && pkt.register_address_field == scratch_reg_adr)
                            s_nxt.scratch_r = pkt.packet_data_field;
                    end
                    set_reset_bit_op, set_fast_clock_op, clear_reset_bit_op:
                    begin
                        // hub has no such bits, so these are no-ops
                    end
                    route_next_op:
                    begin
                        if (to_stick || for_me)
                        begin
                            s_nxt.route_r      = 1'b1;
                            s_nxt.route_chip_r = pkt.chip_select_field;
                        end
                    end
                    chain_reset_op:
                    begin
                        s_nxt.chain_r      = 1'b1;
                        s_nxt.chain_chip_r = pkt.chip_select_field;
                    end
                    eeprom_byte_write_op:
                    begin
                        // a busy engine drops the request rather than queueing it
                        if (for_me && !ee_busy)
                        begin
                            s_nxt.ee_req_r.kind          = eeprom_kind_write;
                            s_nxt.ee_req_r.slave_address = pkt.register_address_field[7:0];
                            s_nxt.ee_req_r.byte_address  = pkt.packet_data_field[7:0];
                            s_nxt.ee_req_r.write_byte    = pkt.packet_data_field[15:8];
                            s_nxt.ee_valid_r             = 1'b1;
                        end
                    end
                    eeprom_random_read_op:
                    begin
                        if (for_me && !ee_busy)
                        begin
                            s_nxt.ee_req_r.kind          = eeprom_kind_setaddr;
                            s_nxt.ee_req_r.slave_address = pkt.register_address_field[7:0];
                            s_nxt.ee_req_r.byte_address  = pkt.packet_data_field[7:0];
                            s_nxt.ee_req_r.write_byte    = 8'h00;
                            s_nxt.ee_valid_r             = 1'b1;
                            s_nxt.ee_st_r                = ee_setaddr;
                            s_nxt.result_r[result_valid_bit] = 1'b0;
                        end
                    end
                    default:
                    begin
                        // reserved encodings change nothing
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            s_r          <= '0;
            s_r.chip_r   <= own_chip_reset;
            s_r.result_r <= result_reset;
            s_r.scratch_r <= scratch_reset;
            s_r.ee_st_r  <= ee_idle;
        end
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign read_valid_out       = s_r.read_valid_r;
    assign read_data_out        = s_r.read_data_r;
    assign forward_valid_out    = s_r.fwd_valid_r;
    assign forward_packet_out   = s_r.fwd_pkt_r;
    assign forward_chip_out     = s_r.fwd_chip_r;
    assign chain_reset_out      = s_r.chain_r;
    assign chain_reset_chip_out = s_r.chain_chip_r;
    assign eeprom_valid_out     = s_r.ee_valid_r;
    assign eeprom_req_out       = s_r.ee_req_r;

endmodule

// ---- tb/expansion_serial_command_decoder_assertions.sv ----
/* checker for the serial command decoder, system-domain outputs.
   bound to the decoder; packets arrive at least six link cycles apart. */
`timescale 1ns/1ps
module expansion_serial_command_decoder_assertions
    import serial_cmd_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        read_valid_out,
    input  wire logic [15:0] read_data_out,
    input  wire logic        forward_valid_out,
    input  wire logic        chain_reset_out,
    input  wire logic        eeprom_valid_out,
    input  wire eeprom_req_t eeprom_req_out,
    input  wire logic        eeprom_ready_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // spaced packets mean no two answers come back to back
    a_read_pulse: assert property (read_valid_out |=> !read_valid_out [*3])
        else $error("read answer pulse too long");
    a_read_holds: assert property (!read_valid_out |-> $stable(read_data_out))
        else $error("read data moved without an answer");
    a_fwd_once: assert property (forward_valid_out |=> !forward_valid_out [*3])
        else $error("routed packet forwarded twice");
    a_chain_pulse: assert property (chain_reset_out |=> !chain_reset_out [*3])
        else $error("chain reset pulse too long");
    a_ee_hold: assert property (eeprom_valid_out && !eeprom_ready_in |=>
        eeprom_valid_out && $stable(eeprom_req_out)) else $error("eeprom request dropped");
    a_ee_order: assert property (eeprom_valid_out && eeprom_ready_in &&
        eeprom_req_out.kind == eeprom_kind_setaddr |=> eeprom_valid_out &&
        eeprom_req_out.kind == eeprom_kind_read && $stable(eeprom_req_out.slave_address))
        else $error("set-address not followed by read");
    a_ee_read_wait: assert property (eeprom_valid_out && eeprom_ready_in &&
        eeprom_req_out.kind == eeprom_kind_read |=> !eeprom_valid_out)
        else $error("request issued during eeprom read");
    a_ee_kind: assert property (eeprom_valid_out |-> eeprom_req_out.kind != 2'h0)
        else $error("eeprom request without a kind");
endmodule

bind expansion_serial_command_decoder expansion_serial_command_decoder_assertions chk_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .read_valid_out(read_valid_out),
    .read_data_out(read_data_out), .forward_valid_out(forward_valid_out),
    .chain_reset_out(chain_reset_out), .eeprom_valid_out(eeprom_valid_out),
    .eeprom_req_out(eeprom_req_out), .eeprom_ready_in(eeprom_ready_in));

// ---- tb/serial_ctl_model.sv ----
/* upstream controller model issuing assembled serial control packets.
   assumes the link clock runs and link reset is released before send. */
`timescale 1ns/1ps
module serial_ctl_model
    import serial_cmd_pkg::*;
(
    input  wire logic link_clk_in,
    output logic      packet_valid_out,
    output packet_t   packet_out
);
    initial
    begin
        packet_valid_out = 1'b0;
        packet_out       = '0;
    end
    // one strobe carries the whole transaction; caller picks the opcode
    task automatic send(input packet_t p);
        @(negedge link_clk_in);
        packet_valid_out = 1'b1;
        packet_out       = p;
        @(negedge link_clk_in);
        packet_valid_out = 1'b0;
        // released lines show garbage, not the last packet
        packet_out       = ~p;
        repeat (6) @(negedge link_clk_in);
    endtask
endmodule

// ---- tb/expansion_serial_command_decoder_test.sv ----
/* self-checking bench for the serial command decoder.
   assumes the controller model and an inline eeprom engine responder. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module expansion_serial_command_decoder_test;
    import serial_cmd_pkg::*;
    localparam logic [4:0] own = 5'h03;
    logic        sys_clk_in = 1'b0, link_clk_in = 1'b0, rst_n_in = 1'b0, lrst_n = 1'b0;
    logic        ee_rdy = 1'b0, ee_done = 1'b0, rdv, fwv, crv, eev, pv;
    logic [7:0]  ee_dat = 8'h00;
    logic [15:0] rdd, rd_v;
    logic [4:0]  fwc, crc, fw_c, cr_c;
    packet_t     pkt, fwp, fw_p;
    eeprom_req_t eeq, ee_log [4];
    int          rd_n = 0, fw_n = 0, cr_n = 0, ee_n = 0, rd_wait = 0, err_total = 0, num_checks = 0;

    always #4 sys_clk_in = ~sys_clk_in;
    initial
    begin
        #1.7;
        forever #3 link_clk_in = ~link_clk_in;
    end

    serial_ctl_model serial_ctl_model_inst (.link_clk_in(link_clk_in), .packet_valid_out(pv), .packet_out(pkt));
    expansion_serial_command_decoder expansion_serial_command_decoder_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in), .link_rst_n_in(lrst_n),
        .own_chip_id_in(own), .packet_valid_in(pv), .packet_in(pkt), .read_valid_out(rdv),
        .read_data_out(rdd), .forward_valid_out(fwv), .forward_packet_out(fwp), .forward_chip_out(fwc),
        .chain_reset_out(crv), .chain_reset_chip_out(crc), .eeprom_valid_out(eev), .eeprom_req_out(eeq),
        .eeprom_ready_in(ee_rdy), .eeprom_done_in(ee_done), .eeprom_data_in(ee_dat));

    // ------------------------------------------------------------
    // output monitor and eeprom engine responder
    // ------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (rdv === 1'b1) begin rd_n++; rd_v = rdd; end
        if (fwv === 1'b1) begin fw_n++; fw_p = fwp; fw_c = fwc; end
        if (crv === 1'b1) begin cr_n++; cr_c = crc; end
        if (eev === 1'b1 && ee_rdy === 1'b1)
        begin
            ee_log[ee_n % 4] = eeq;
            ee_n++;
        end
    end
    // ready alternates so requests see both stall and prompt acceptance
    always @(negedge sys_clk_in)
    begin
        // a read request raised at the edge that accepted the set-address starts the engine countdown
        if (eev === 1'b1 && ee_rdy === 1'b1 && eeq.kind === eeprom_kind_read) rd_wait = 10;
        ee_rdy <= ~ee_rdy;
        ee_dat <= (rd_wait > 0) ? 8'hC8 : ~ee_dat;
        if (rd_wait == 5) ee_done <= ~ee_done;
        if (rd_wait > 0) rd_wait--;
    end

    task automatic op(input logic [3:0] o, input logic [4:0] c, input logic [11:0] a, input logic [15:0] d);
        serial_ctl_model_inst.send({o, c, a, d});
        repeat (4) @(negedge sys_clk_in);
    endtask
    task automatic rd(input logic [4:0] c, input logic [11:0] a, input logic [15:0] e);
        int n0;
        n0 = rd_n;
        op(register_read_op, c, a, 16'h0000);
        for (int i = 0; i < 20 && rd_n == n0; i++) @(negedge sys_clk_in);
        `CHK(rd_n, n0 + 1)
        `CHK(rd_v, e)
    endtask
    task automatic s_regs;
        int n0;
        op(register_write_op, own, 12'h041, 16'hA5C3);
        rd(own, 12'h041, 16'hA5C3);
        rd(own, 12'h123, 16'h0000);
        op(register_write_op, chip_all_hubs, 12'h041, 16'h5A3C);
        op(register_write_op, 5'h05, 12'h041, 16'hFFFF);
        rd(own, 12'h041, 16'h5A3C);
        n0 = rd_n;
        op(register_read_op, 5'h05, 12'h041, 16'h0000);
        `CHK(rd_n, n0)
    endtask
    task automatic s_nops;
        logic [3:0] tbl [10] = '{4'h2, 4'h4, 4'hB, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA, 4'hC, 4'hF};
        int         n0;
        n0 = fw_n + cr_n + ee_n;
        foreach (tbl[i]) op(tbl[i], own, 12'h041, 16'hFFFF);
        `CHK(fw_n + cr_n + ee_n, n0)
        rd(own, 12'h041, 16'h5A3C);
    endtask
    task automatic s_route;
        int n0;
        n0 = fw_n;
        op(route_next_op, 5'h12, 12'h000, 16'h0000);
        op(register_write_op, own, 12'h041, 16'h1234);
        `CHK(fw_n, n0 + 1)
        `CHK(fw_p, {register_write_op, own, 12'h041, 16'h1234})
        `CHK(fw_c, 5'h12)
        rd(own, 12'h041, 16'h5A3C);
        op(register_write_op, own, 12'h041, 16'h7777);
        rd(own, 12'h041, 16'h7777);
        `CHK(fw_n, n0 + 1)
    endtask
    task automatic s_chain;
        int n0;
        n0 = cr_n;
        op(chain_reset_op, 5'h11, 12'h000, 16'h0000);
        `CHK(cr_n, n0 + 1)
        `CHK(cr_c, 5'h11)
    endtask
    task automatic s_eeprom;
        int n0;
        n0 = ee_n;
        op(eeprom_byte_write_op, own, 12'h0A6, 16'h5B21);
        for (int i = 0; i < 50 && ee_n == n0; i++) @(negedge sys_clk_in);
        `CHK(ee_log[n0 % 4], {eeprom_kind_write, 8'hA6, 8'h21, 8'h5B})
        n0 = ee_n;
        op(eeprom_random_read_op, own, 12'h0A4, 16'h0037);
        for (int i = 0; i < 50 && (ee_n < n0 + 2 || rd_wait > 0); i++) @(negedge sys_clk_in);
        `CHK(ee_log[n0 % 4].kind, eeprom_kind_setaddr)
        `CHK({ee_log[n0 % 4].slave_address, ee_log[n0 % 4].byte_address}, 16'hA437)
        `CHK(ee_log[(n0 + 1) % 4].kind, eeprom_kind_read)
        `CHK(ee_log[(n0 + 1) % 4].slave_address, 8'hA4)
        repeat (6) @(negedge sys_clk_in);
        rd(own, eeprom_read_result_adr, 16'h80C8);
        rd(own, eeprom_read_result_adr, 16'h00C8);
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #60000;
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        @(negedge link_clk_in);
        lrst_n = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        s_regs();
        s_nops();
        s_route();
        s_chain();
        s_eeprom();
        tally_and_finish();
    end
endmodule
